// ==== verilog/uefc_consts.svh ====
// register offsets, field positions, reset values and trigger tables
`ifndef UEFC_CONSTS_SVH
`define UEFC_CONSTS_SVH

// register offsets on the 3-bit address
`define UEFC_OFS_DVL        3'h0
`define UEFC_OFS_DVH        3'h1
`define UEFC_OFS_IEN        3'h1
`define UEFC_OFS_FFC_IDN    3'h2
`define UEFC_OFS_FEA        3'h2
`define UEFC_OFS_LCR        3'h3
`define UEFC_OFS_MDM        3'h4
`define UEFC_OFS_FTH        3'h6
`define UEFC_OFS_TRG        3'h7
`define UEFC_OFS_XOFF2      3'h7
`define UEFC_OFS_FRDY       3'h7

// line-control key that opens the enhanced bank
`define UEFC_LCR_ENH_KEY    8'hBF
`define UEFC_LCR_DLAB_BIT   7

// feature control fields
`define UEFC_FEA_CTS_BIT    7
`define UEFC_FEA_RTS_BIT    6
`define UEFC_FEA_SPC_BIT    5
`define UEFC_FEA_ENH_BIT    4

// other control fields
`define UEFC_IEN_SLEEP_BIT  4
`define UEFC_MDM_RTS_BIT    1
`define UEFC_MDM_FRDY_BIT   2
`define UEFC_MDM_LOOP_BIT   4
`define UEFC_MDM_BANK_BIT   6
`define UEFC_IDN_SPC_BIT    4

// reset values
`define UEFC_RST_BYTE       8'h00
`define UEFC_RST_IDN        8'h01

// fifo-control trigger tables, in characters
`define UEFC_FFC_RX_TRIG0   7'h08
`define UEFC_FFC_RX_TRIG1   7'h10
`define UEFC_FFC_RX_TRIG2   7'h38
`define UEFC_FFC_RX_TRIG3   7'h3C
`define UEFC_FFC_TX_TRIG0   7'h08
`define UEFC_FFC_TX_TRIG1   7'h10
`define UEFC_FFC_TX_TRIG2   7'h20
`define UEFC_FFC_TX_TRIG3   7'h38

`endif

// ==== verilog/uefc_pkg.sv ====
// types shared by the enhanced-feature control block
`default_nettype none
package uefc_pkg;
  // register selected by one bus access
  typedef enum logic [3:0] {
    UEFC_ACC_NONE,
    UEFC_ACC_DVL,
    UEFC_ACC_DVH,
    UEFC_ACC_IEN,
    UEFC_ACC_FFC_IDN,
    UEFC_ACC_LCR,
    UEFC_ACC_MDM,
    UEFC_ACC_FEA,
    UEFC_ACC_XOFF2,
    UEFC_ACC_FTH,
    UEFC_ACC_TRG,
    UEFC_ACC_FRDY
  } uefc_acc_e;
endpackage
`default_nettype wire

// ==== verilog/uefc_flow_ctl.sv ====
// hardware flow control: clear-to-send stop and request-to-send hysteresis
`include "uefc_consts.svh"
`default_nettype none
module uefc_flow_ctl
  import uefc_pkg::*;
#(
  parameter int LVL_W = 7
) (
  input  wire logic             sys_clk,      // device clock
  input  wire logic             rst_n,        // async reset, active low
  input  wire logic             ce,           // clock enable
  input  wire logic             auto_cts_en,  // clear-to-send stop enabled
  input  wire logic             auto_rts_en,  // request-to-send control enabled
  input  wire logic             cts_n,        // clear-to-send pin, active low
  input  wire logic             mdm_rts,      // software request-to-send bit
  input  wire logic [LVL_W-1:0] rx_level,     // receive fifo fill level
  input  wire logic [3:0]       halt_lvl,     // halt threshold over four
  input  wire logic [3:0]       resume_lvl,   // resume threshold over four
  output logic                  tx_stop,      // transmitter must hold off
  output logic                  rts_n         // request-to-send pin, active low
);

  logic             halted;
  logic [LVL_W-1:0] halt_cnt;
  logic [LVL_W-1:0] resume_cnt;

  // thresholds scaled to bytes, steps of four
  assign halt_cnt   = LVL_W'({halt_lvl, 2'b00});
  assign resume_cnt = LVL_W'({resume_lvl, 2'b00});

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_stop <= 1'b0;
    end else if (ce) begin
      tx_stop <= auto_cts_en & cts_n;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      halted <= 1'b0;
    end else if (ce) begin
      if (!auto_rts_en) begin
        halted <= 1'b0;
      end else if (rx_level >= halt_cnt) begin
        halted <= 1'b1;
      end else if (rx_level <= resume_cnt) begin
        halted <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_n <= 1'b1;
    end else if (ce) begin
      if (auto_rts_en) begin
        rts_n <= (rx_level >= halt_cnt) | (halted & (rx_level > resume_cnt));
      end else begin
        rts_n <= ~mdm_rts;
      end
    end
  end

endmodule
`default_nettype wire

// ==== verilog/uefc_enh_ctl.sv ====
// enhanced-feature register bank for one serial channel
`include "uefc_consts.svh"
`default_nettype none

// Notes on behaviour
// - cts flow on: stop transmit while cts high
// - auto rts: high at halt, low at resume
// - special char matches second stop: flag, still stored
// - enhanced enable gates upper control bit writes
// - low feature nibble picks software flow mode
// - sixteen-bit divisor in two byte registers
// - divisor writes only while sleep disabled
// - threshold register: resume high nibble, halt low
// - threshold writes need enhanced and bank bits
// - trigger register: rx high nibble, tx low
// - zero trigger nibble falls back to fifo control
// - trigger writes need enhanced and bank bits
// - ready word: rx bits 5:4, tx 1:0
// - flow and special detect off after reset
module uefc_enh_ctl
  import uefc_pkg::*;
#(
  parameter bit IS_CHANNEL_B = 1'b0,
  parameter int LVL_W        = 7
) (
  input  wire logic             sys_clk,           // device clock
  input  wire logic             rst_n,             // async reset, active low
  input  wire logic             ce,                // clock enable
  input  wire logic             select_channel_a_n,// chip select channel a
  input  wire logic             select_channel_b_n,// chip select channel b
  input  wire logic [2:0]       addr,              // register address
  input  wire logic [7:0]       wdata,             // write data
  input  wire logic             wr_n,              // write strobe, active low
  input  wire logic             rd_n,              // read strobe, active low
  input  wire logic             cts_n,             // clear-to-send pin
  input  wire logic [LVL_W-1:0] rx_level,          // receive fifo level
  input  wire logic             rx_char_valid,     // received char pulse
  input  wire logic [7:0]       rx_char,           // received char
  input  wire logic [1:0]       rx_ready_ba,       // rx fifo status b,a
  input  wire logic [1:0]       tx_ready_ba,       // tx fifo status b,a
  output logic [7:0]            rdata,             // read data
  output logic [15:0]           divisor,           // baud divisor
  output logic [3:0]            sw_flow_mode,      // software flow select
  output logic [LVL_W-1:0]      rx_trigger,        // effective rx trigger
  output logic [LVL_W-1:0]      tx_trigger,        // effective tx trigger
  output logic [7:0]            interrupt_enable_reg, // interrupt enables
  output logic [7:0]            fifo_ctrl_reg,     // fifo control bits
  output logic [7:0]            modem_ctrl_reg,    // modem control bits
  output logic                  special_char_flag, // special char seen
  output logic                  tx_stop,           // transmit hold
  output logic                  rts_n              // request-to-send pin
);

  logic [7:0] line_ctrl;
  logic [7:0] feature_ctrl;
  logic [7:0] divisor_lo;
  logic [7:0] divisor_hi;
  logic [7:0] flow_threshold_reg;
  logic [7:0] trigger_level_reg;
  logic [7:0] stop_char2;
  logic       wr_prev;
  logic       rd_prev;
  logic       own_cs;
  logic       any_cs;
  logic       wr_take;
  logic       rd_take;
  logic       bank_open;
  uefc_acc_e  wr_acc;
  uefc_acc_e  rd_acc;
  logic       rd_ok;
  logic [7:0] next_rdata;
  logic [7:0] ready_word;
  logic [7:0] identity;

  // which register a given address reaches under the current bank state
  function automatic uefc_acc_e decode_acc(
    input logic [2:0] a,
    input logic [7:0] lcr,
    input logic       enh_bank,
    input logic       frdy_on,
    input logic       is_read
  );
    uefc_acc_e r;
    r = UEFC_ACC_NONE;
    if (a == `UEFC_OFS_LCR) begin
      r = UEFC_ACC_LCR;
    end else if (lcr[`UEFC_LCR_DLAB_BIT] && a == `UEFC_OFS_DVL) begin
      r = UEFC_ACC_DVL;
    end else if (lcr[`UEFC_LCR_DLAB_BIT] && a == `UEFC_OFS_DVH) begin
      r = UEFC_ACC_DVH;
    end else if (lcr == `UEFC_LCR_ENH_KEY) begin
      if (a == `UEFC_OFS_FEA) begin
        r = UEFC_ACC_FEA;
      end else if (a == `UEFC_OFS_XOFF2) begin
        r = UEFC_ACC_XOFF2;
      end
    end else if (!lcr[`UEFC_LCR_DLAB_BIT] && a == `UEFC_OFS_IEN) begin
      r = UEFC_ACC_IEN;
    end else if (a == `UEFC_OFS_FFC_IDN) begin
      r = UEFC_ACC_FFC_IDN;
    end else if (a == `UEFC_OFS_MDM) begin
      r = UEFC_ACC_MDM;
    end else if (a == `UEFC_OFS_FTH && enh_bank) begin
      r = UEFC_ACC_FTH;
    end else if (a == `UEFC_OFS_FRDY && is_read && frdy_on) begin
      r = UEFC_ACC_FRDY;
    end else if (a == `UEFC_OFS_TRG && enh_bank) begin
      r = UEFC_ACC_TRG;
    end
    return r;
  endfunction

  // chip selects and strobe edges
  assign own_cs    = IS_CHANNEL_B ? ~select_channel_b_n : ~select_channel_a_n;
  assign any_cs    = ~select_channel_a_n | ~select_channel_b_n;
  assign wr_take   = own_cs & ~wr_n & wr_prev;
  assign rd_take   = ~rd_n & rd_prev;
  assign bank_open = feature_ctrl[`UEFC_FEA_ENH_BIT] & modem_ctrl_reg[`UEFC_MDM_BANK_BIT];

  // access decode for both directions
  assign wr_acc = decode_acc(addr, line_ctrl, bank_open, 1'b0, 1'b0);
  assign rd_acc = decode_acc(addr, line_ctrl, bank_open,
                             modem_ctrl_reg[`UEFC_MDM_FRDY_BIT] & ~modem_ctrl_reg[`UEFC_MDM_LOOP_BIT], 1'b1);
  assign rd_ok  = (rd_acc == UEFC_ACC_FRDY) ? any_cs : own_cs;

  assign ready_word = {2'b00, rx_ready_ba, 2'b00, tx_ready_ba};
  assign identity   = special_char_flag ? 8'h10 : `UEFC_RST_IDN;

  // strobe history for edge detection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_prev <= 1'b1;
      rd_prev <= 1'b1;
    end else if (ce) begin
      wr_prev <= wr_n;
      rd_prev <= rd_n;
    end
  end

  // line control, always writable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_ctrl <= `UEFC_RST_BYTE;
    end else if (ce && wr_take && wr_acc == UEFC_ACC_LCR) begin
      line_ctrl <= wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      feature_ctrl <= `UEFC_RST_BYTE;
      stop_char2   <= `UEFC_RST_BYTE;
    end else if (ce && wr_take) begin
      if (wr_acc == UEFC_ACC_FEA) begin
        feature_ctrl <= wdata;
      end
      if (wr_acc == UEFC_ACC_XOFF2) begin
        stop_char2 <= wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_enable_reg <= `UEFC_RST_BYTE;
      fifo_ctrl_reg        <= `UEFC_RST_BYTE;
      modem_ctrl_reg       <= `UEFC_RST_BYTE;
    end else if (ce && wr_take) begin
      if (wr_acc == UEFC_ACC_IEN) begin
        interrupt_enable_reg <= feature_ctrl[`UEFC_FEA_ENH_BIT] ? wdata
                                : {interrupt_enable_reg[7:4], wdata[3:0]};
      end
      if (wr_acc == UEFC_ACC_FFC_IDN) begin
        fifo_ctrl_reg <= feature_ctrl[`UEFC_FEA_ENH_BIT] ? wdata
                         : {wdata[7:6], fifo_ctrl_reg[5:4], wdata[3:0]};
      end
      if (wr_acc == UEFC_ACC_MDM) begin
        modem_ctrl_reg <= feature_ctrl[`UEFC_FEA_ENH_BIT] ? wdata
                          : {modem_ctrl_reg[7:5], wdata[4:0]};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divisor_lo <= `UEFC_RST_BYTE;
      divisor_hi <= `UEFC_RST_BYTE;
    end else if (ce && wr_take && !interrupt_enable_reg[`UEFC_IEN_SLEEP_BIT]) begin
      if (wr_acc == UEFC_ACC_DVL) begin
        divisor_lo <= wdata;
      end
      if (wr_acc == UEFC_ACC_DVH) begin
        divisor_hi <= wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divisor <= 16'h0000;
    end else if (ce) begin
      divisor <= {divisor_hi, divisor_lo};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flow_threshold_reg <= `UEFC_RST_BYTE;
      trigger_level_reg  <= `UEFC_RST_BYTE;
    end else if (ce && wr_take) begin
      if (wr_acc == UEFC_ACC_FTH) begin
        flow_threshold_reg <= wdata;
      end
      if (wr_acc == UEFC_ACC_TRG) begin
        trigger_level_reg <= wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_flow_mode <= 4'h0;
    end else if (ce) begin
      sw_flow_mode <= feature_ctrl[3:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_trigger <= LVL_W'(`UEFC_FFC_RX_TRIG0);
      tx_trigger <= LVL_W'(`UEFC_FFC_TX_TRIG0);
    end else if (ce) begin
      if (trigger_level_reg[7:4] != 4'h0) begin
        rx_trigger <= LVL_W'({trigger_level_reg[7:4], 2'b00});
      end else begin
        unique case (fifo_ctrl_reg[7:6])
          2'b00: rx_trigger <= LVL_W'(`UEFC_FFC_RX_TRIG0);
          2'b01: rx_trigger <= LVL_W'(`UEFC_FFC_RX_TRIG1);
          2'b10: rx_trigger <= LVL_W'(`UEFC_FFC_RX_TRIG2);
          2'b11: rx_trigger <= LVL_W'(`UEFC_FFC_RX_TRIG3);
        endcase
      end
      if (trigger_level_reg[3:0] != 4'h0) begin
        tx_trigger <= LVL_W'({trigger_level_reg[3:0], 2'b00});
      end else begin
        unique case (fifo_ctrl_reg[5:4])
          2'b00: tx_trigger <= LVL_W'(`UEFC_FFC_TX_TRIG0);
          2'b01: tx_trigger <= LVL_W'(`UEFC_FFC_TX_TRIG1);
          2'b10: tx_trigger <= LVL_W'(`UEFC_FFC_TX_TRIG2);
          2'b11: tx_trigger <= LVL_W'(`UEFC_FFC_TX_TRIG3);
        endcase
      end
    end
  end

  // special char match, set beats read clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      special_char_flag <= 1'b0;
    end else if (ce) begin
      if (feature_ctrl[`UEFC_FEA_SPC_BIT] && rx_char_valid && rx_char == stop_char2) begin
        special_char_flag <= 1'b1;
      end else if (rd_take && own_cs && rd_acc == UEFC_ACC_FFC_IDN) begin
        special_char_flag <= 1'b0;
      end
    end
  end

  // read multiplexer
  always_comb begin
    next_rdata = 8'h00;
    if (!rd_n && rd_ok) begin
      unique case (rd_acc)
        UEFC_ACC_DVL:     next_rdata = divisor_lo;
        UEFC_ACC_DVH:     next_rdata = divisor_hi;
        UEFC_ACC_IEN:     next_rdata = interrupt_enable_reg;
        UEFC_ACC_FFC_IDN: next_rdata = identity;
        UEFC_ACC_LCR:     next_rdata = line_ctrl;
        UEFC_ACC_MDM:     next_rdata = modem_ctrl_reg;
        UEFC_ACC_FEA:     next_rdata = feature_ctrl;
        UEFC_ACC_XOFF2:   next_rdata = stop_char2;
        UEFC_ACC_FTH:     next_rdata = flow_threshold_reg;
        UEFC_ACC_TRG:     next_rdata = trigger_level_reg;
        UEFC_ACC_FRDY:    next_rdata = ready_word;
        UEFC_ACC_NONE:    next_rdata = 8'h00;
        default:          next_rdata = 8'h00;
      endcase
    end
  end

  // registered read data
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= next_rdata;
    end
  end

  uefc_flow_ctl #(
    .LVL_W (LVL_W)
  ) u_flow (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .auto_cts_en (feature_ctrl[`UEFC_FEA_CTS_BIT]),
    .auto_rts_en (feature_ctrl[`UEFC_FEA_RTS_BIT]),
    .cts_n       (cts_n),
    .mdm_rts     (modem_ctrl_reg[`UEFC_MDM_RTS_BIT]),
    .rx_level    (rx_level),
    .halt_lvl    (flow_threshold_reg[3:0]),
    .resume_lvl  (flow_threshold_reg[7:4]),
    .tx_stop     (tx_stop),
    .rts_n       (rts_n)
  );

endmodule
`default_nettype wire

// ==== sim/uefc_chk.sv ====
// assertion checker bound to the enhanced-feature register bank
`default_nettype none
module uefc_chk #(
  parameter bit IS_CHANNEL_B = 1'b0,
  parameter int LVL_W        = 7
) (
  input wire logic             sys_clk,              // clock
  input wire logic             rst_n,                // reset
  input wire logic             ce,                   // clock enable
  input wire logic             select_channel_a_n,   // select a
  input wire logic             select_channel_b_n,   // select b
  input wire logic [2:0]       addr,                 // address
  input wire logic [7:0]       wdata,                // write data
  input wire logic             wr_n,                 // write strobe
  input wire logic             rd_n,                 // read strobe
  input wire logic             cts_n,                // clear-to-send
  input wire logic [LVL_W-1:0] rx_level,             // fifo level
  input wire logic             rx_char_valid,        // char pulse
  input wire logic [7:0]       rx_char,              // char
  input wire logic [1:0]       rx_ready_ba,          // rx status
  input wire logic [1:0]       tx_ready_ba,          // tx status
  input wire logic [7:0]       rdata,                // read data
  input wire logic [15:0]      divisor,              // divisor
  input wire logic [7:0]       interrupt_enable_reg, // enables
  input wire logic [7:0]       fifo_ctrl_reg,        // fifo control
  input wire logic [7:0]       modem_ctrl_reg,       // modem control
  input wire logic             special_char_flag,    // special flag
  input wire logic             tx_stop,              // transmit hold
  input wire logic             rts_n                 // request-to-send
);
  logic       wr_q;
  logic [7:0] lcr_m;
  logic [7:0] feat_m;
  logic [7:0] thr_m;
  logic [7:0] xoff_m;
  wire        own_n = IS_CHANNEL_B ? select_channel_b_n : select_channel_a_n;
  wire        bf    = lcr_m == 8'hBF;
  wire        wr_ev = ce && !own_n && !wr_n && wr_q;

  // mirror of the write-only views needed below
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q   <= 1'b1;
      lcr_m  <= 8'h00;
      feat_m <= 8'h00;
      thr_m  <= 8'h00;
      xoff_m <= 8'h00;
    end else if (ce) begin
      wr_q <= wr_n;
      if (wr_ev && addr == 3'h3) lcr_m <= wdata;
      if (wr_ev && addr == 3'h2 && bf) feat_m <= wdata;
      if (wr_ev && addr == 3'h6 && !bf && feat_m[4] && modem_ctrl_reg[6]) thr_m <= wdata;
      if (wr_ev && addr == 3'h7 && bf) xoff_m <= wdata;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_rd_idle;
    $past(rd_n) |-> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
  property p_ready;
    $past(!rd_n && !(select_channel_a_n && select_channel_b_n) && addr == 3'h7 && !bf &&
      modem_ctrl_reg[2] && !modem_ctrl_reg[4]) |-> rdata == {2'b00, $past(rx_ready_ba), 2'b00, $past(tx_ready_ba)};
  endproperty
  a_ready: assert property (p_ready) else $error("ready word wrong");
  property p_div_sleep;
    interrupt_enable_reg[4] && $past(interrupt_enable_reg[4], 3) |-> $stable(divisor);
  endproperty
  a_div_sleep: assert property (p_div_sleep) else $error("divisor moved in sleep");
  property p_gate;
    !feat_m[4] && $past(!feat_m[4]) |-> $stable(interrupt_enable_reg[7:4]) && $stable(fifo_ctrl_reg[5:4])
      && $stable(modem_ctrl_reg[7:5]);
  endproperty
  a_gate: assert property (p_gate) else $error("gated bits written");
  property p_cts;
    tx_stop == $past(feat_m[7] && cts_n);
  endproperty
  a_cts: assert property (p_cts) else $error("transmit hold wrong");
  property p_rts_halt;
    $past(feat_m[6] && rx_level >= {thr_m[3:0], 2'b00}) |-> rts_n;
  endproperty
  a_rts_halt: assert property (p_rts_halt) else $error("halt not signalled");
  property p_rts_resume;
    $past(feat_m[6] && rx_level <= {thr_m[7:4], 2'b00} && rx_level < {thr_m[3:0], 2'b00}) |-> !rts_n;
  endproperty
  a_rts_resume: assert property (p_rts_resume) else $error("resume not signalled");
  property p_spc;
    $past(feat_m[5] && rx_char_valid && rx_char == xoff_m) |-> special_char_flag;
  endproperty
  a_spc: assert property (p_spc) else $error("special char missed");

  c_halt: cover property ($rose(rts_n) && feat_m[6]);
  c_spc: cover property ($rose(special_char_flag));
  c_ready: cover property (!rd_n && select_channel_a_n && !select_channel_b_n);
endmodule

bind uefc_enh_ctl uefc_chk #(.IS_CHANNEL_B(IS_CHANNEL_B), .LVL_W(LVL_W)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .select_channel_a_n(select_channel_a_n),
  .select_channel_b_n(select_channel_b_n), .addr(addr), .wdata(wdata), .wr_n(wr_n), .rd_n(rd_n),
  .cts_n(cts_n), .rx_level(rx_level), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
  .rx_ready_ba(rx_ready_ba), .tx_ready_ba(tx_ready_ba), .rdata(rdata), .divisor(divisor),
  .interrupt_enable_reg(interrupt_enable_reg), .fifo_ctrl_reg(fifo_ctrl_reg), .modem_ctrl_reg(modem_ctrl_reg),
  .special_char_flag(special_char_flag), .tx_stop(tx_stop), .rts_n(rts_n));
`default_nettype wire

// ==== sim/uefc_terminal.sv ====
// remote terminal model on the handshake lines
`default_nettype none
module uefc_terminal (
  input  wire logic       sys_clk,       // clock
  input  wire logic       rst_n,         // reset
  input  wire logic       send,          // keep sending
  input  wire logic       drain,         // host empties fifo
  input  wire logic       cts_hold,      // pause the device
  input  wire logic       rts_n,         // device says stop
  output logic            cts_n,         // clear-to-send
  output logic            rx_char_valid, // char strobe
  output logic [7:0]      rx_char,       // char, scrambled idle
  output logic [6:0]      rx_level       // fifo fill
);
  logic [1:0] gap;
  logic [7:0] cnt;
  wire        push = send && !rts_n && gap == 2'h0 && rx_level < 7'h40;

  // no stale char between strobes
  assign rx_char = rx_char_valid ? cnt : ~cnt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap           <= 2'h0;
      cnt           <= 8'h50;
      rx_char_valid <= 1'b0;
      rx_level      <= 7'h00;
      cts_n         <= 1'b0;
    end else begin
      gap           <= gap + 2'h1;
      cts_n         <= cts_hold;
      rx_char_valid <= push;
      cnt           <= cnt + {7'h00, push};
      rx_level      <= rx_level + {6'h00, push} - {6'h00, drain && rx_level != 7'h00};
    end
  end
endmodule
`default_nettype wire

// ==== sim/test_uart_enhanced_flow_thresholds.sv ====
// testbench: register model, flow control and special detect
`default_nettype none
module test_uart_enhanced_flow_thresholds;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, rst_n = 0, ce = 1, select_channel_a_n = 0, select_channel_b_n = 1;
  logic        wr_n = 1, rd_n = 1, send = 0, drain = 0, cts_hold = 0, watch = 0;
  logic [2:0]  addr = 0;
  logic [7:0]  wdata = 0, rdata, rx_char, interrupt_enable_reg, fifo_ctrl_reg, modem_ctrl_reg;
  logic [1:0]  rx_ready_ba = 0, tx_ready_ba = 0;
  logic [15:0] divisor;
  logic [3:0]  sw_flow_mode;
  logic [6:0]  rx_trigger, tx_trigger, rx_level;
  logic        special_char_flag, tx_stop, rts_n, cts_n, rx_char_valid;
  logic [31:0] lf;
  int          lcr, feat, ien, ffc, mdm, dvl, dvh, thr, trig, xoff, flag, rts_e, stop_e;
  int          n_errors = 0, check_count = 0, cycles = 0;
  int          rx_tab[4] = '{8, 16, 56, 60};
  int          tx_tab[4] = '{8, 16, 32, 56};
  int          lcr_tab[4] = '{8'h00, 8'h80, 8'hBF, 8'hBF};

  uefc_enh_ctl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .select_channel_a_n(select_channel_a_n),
    .select_channel_b_n(select_channel_b_n), .addr(addr), .wdata(wdata), .wr_n(wr_n), .rd_n(rd_n),
    .cts_n(cts_n), .rx_level(rx_level), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_ready_ba(rx_ready_ba), .tx_ready_ba(tx_ready_ba), .rdata(rdata), .divisor(divisor),
    .sw_flow_mode(sw_flow_mode), .rx_trigger(rx_trigger), .tx_trigger(tx_trigger),
    .interrupt_enable_reg(interrupt_enable_reg), .fifo_ctrl_reg(fifo_ctrl_reg), .modem_ctrl_reg(modem_ctrl_reg),
    .special_char_flag(special_char_flag), .tx_stop(tx_stop), .rts_n(rts_n));
  uefc_terminal u_term (.sys_clk(sys_clk), .rst_n(rst_n), .send(send), .drain(drain), .cts_hold(cts_hold),
    .rts_n(rts_n), .cts_n(cts_n), .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_level(rx_level));

  // clock and hang guard
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_errors++;
      $display("unexpected at %0t: timeout", $time);
      end_of_test();
    end
  end

  function automatic int rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return int'(lf & 32'h7FFFFFFF);
  endfunction

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(logic [15:0] got, int exp);
    check_count++;
    if (got !== 16'(exp)) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // register model: what a read returns
  function automatic int mdl_rd(int a, bit own);
    bit bf;
    bf = lcr == 8'hBF;
    if (a == 7 && !bf && mdm[2] && !mdm[4]) return {rx_ready_ba, 2'b00, tx_ready_ba};
    if (!own) return 0;
    case (a)
      0: return lcr[7] ? dvl : 0;
      1: return lcr[7] ? dvh : ien;
      2: return bf ? feat : (flag ? 8'h10 : 8'h01);
      3: return lcr;
      4: return bf ? 0 : mdm;
      6: return (!bf && feat[4] && mdm[6]) ? thr : 0;
      7: return bf ? xoff : (feat[4] && mdm[6]) ? trig : 0;
      default: return 0;
    endcase
  endfunction

  task automatic wr(int a, int d);
    bit bf;
    bit enh;
    addr = 3'(a);
    wdata = 8'(d);
    wr_n = 0;
    @(posedge sys_clk);
    #2 wr_n = 1;
    @(posedge sys_clk);
    #2 bf = lcr == 8'hBF;
    enh = feat[4];
    case (a)
      0: if (lcr[7] && !ien[4]) dvl = d;
      1: if (!lcr[7]) ien = enh ? d : ien & 8'hF0 | d & 8'h0F;
         else if (!ien[4]) dvh = d;
      2: if (bf) feat = d;
         else ffc = enh ? d : ffc & 8'h30 | d & 8'hCF;
      3: lcr = d;
      4: if (!bf) mdm = enh ? d : mdm & 8'hE0 | d & 8'h1F;
      6: if (!bf && enh && mdm[6]) thr = d;
      7: if (bf) xoff = d;
         else if (enh && mdm[6]) trig = d;
      default: ;
    endcase
  endtask

  task automatic rd(int a, bit own);
    int e;
    e = mdl_rd(a, own);
    addr = 3'(a);
    select_channel_a_n = !own;
    select_channel_b_n = own;
    rd_n = 0;
    @(posedge sys_clk);
    #2 chk(rdata, e);
    rd_n = 1;
    select_channel_a_n = 0;
    select_channel_b_n = 1;
    if (own && a == 2 && lcr != 8'hBF) flag = 0;
    @(posedge sys_clk);
    #2;
  endtask

  task automatic check_all();
    chk(divisor, dvh * 256 + dvl);
    chk(sw_flow_mode, feat & 15);
    chk(rx_trigger, trig[7:4] ? trig[7:4] * 4 : rx_tab[ffc[7:6]]);
    chk(tx_trigger, trig[3:0] ? trig[3:0] * 4 : tx_tab[ffc[5:4]]);
    chk(interrupt_enable_reg, ien);
    chk(fifo_ctrl_reg, ffc);
    chk(modem_ctrl_reg, mdm);
  endtask

  task automatic wait_rts(logic v);
    for (int i = 0; i < 400 && rts_n !== v; i++) @(posedge sys_clk);
    #2 chk(rts_n, v);
  endtask

  // per-cycle flow model while the terminal is live
  always @(posedge sys_clk) begin
    if (watch) begin
      chk(rts_n, rts_e);
      chk(tx_stop, stop_e);
      chk(special_char_flag, flag);
      if (rx_level >= thr[3:0] * 4) rts_e = 1;
      else if (rx_level <= thr[7:4] * 4) rts_e = 0;
      stop_e = feat[7] && cts_n;
      if (feat[5] && rx_char_valid && rx_char == xoff) flag = 1;
    end
  end

  initial begin
    {lcr, feat, ien, ffc, mdm, dvl, dvh, thr, trig, xoff, flag} = '0;
    lf = 66350;
    repeat (10) @(posedge sys_clk);
    #2 rst_n = 1;
    @(posedge sys_clk);
    #2 check_all();
    chk({rts_n, tx_stop, special_char_flag}, 4);
    repeat (300) begin
      rx_ready_ba = 2'(rnd());
      tx_ready_ba = 2'(rnd());
      case (rnd() & 7)
        0: wr(3, lcr_tab[rnd() & 3]);
        1: wr(2, rnd() & 8'hFF);
        6: rd(rnd() & 7, 1);
        7: rd(7, 0);
        default: wr(rnd() & 7, rnd() & 8'hFF);
      endcase
      check_all();
    end
    wr(3, 8'hBF);
    wr(2, 8'h10);
    wr(7, 8'h55);
    wr(3, 8'h00);
    wr(4, 8'h40);
    wr(6, 8'h25);
    wr(7, 8'h3A);
    wr(4, 8'h04);
    wr(6, 8'h77);
    rd(7, 0);
    wr(4, 8'h44);
    rd(6, 1);
    rd(7, 1);
    wr(3, 8'hBF);
    wr(2, 8'hF3);
    wr(3, 8'h00);
    check_all();
    rts_e = 0;
    stop_e = 0;
    watch = 1;
    send = 1;
    wait_rts(1);
    chk(rx_level >= 7'd20, 1);
    cts_hold = 1;
    repeat (12) @(posedge sys_clk);
    #2 cts_hold = 0;
    drain = 1;
    wait_rts(0);
    chk(rx_level <= 7'd8, 1);
    drain = 0;
    send = 0;
    repeat (8) @(posedge sys_clk);
    #2 watch = 0;
    chk(special_char_flag, 1);
    rd(2, 1);
    rd(2, 1);
    end_of_test();
  end
endmodule
`default_nettype wire
